//--- wdlt_pkg.sv
// Operation
// - Late-interrupt flag sets when no feed completes before the interrupt threshold.
// - Late event raises the interrupt only while interrupt-allow is 1; flag sets anyway.
// - Enable bit turns the watchdog on at 1, off at 0; resets to 0.
// - Reset selector picks 2^(31-code) clock periods, 0x0 to 0xF.
// - Interrupt selector picks 2^(31-code) clock periods, 0x0 to 0xF.
// - Reset-allow bit gates whether a late-reset event resets the system.
// - Feed is writes 0xA5 then 0x5A to the feed register; clears the counter.
package wdlt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int WDLT_ADDR_W = 8;
  localparam int WDLT_DATA_W = 32;
  localparam logic [WDLT_ADDR_W-1:0] WDLT_OFF_CTRL = 8'h00;
  localparam logic [WDLT_ADDR_W-1:0] WDLT_OFF_FEED = 8'h04;
  localparam logic [WDLT_ADDR_W-1:0] WDLT_OFF_CNT = 8'h0C;
  localparam logic [WDLT_ADDR_W-1:0] WDLT_OFF_STAT = 8'h10;
  localparam logic [WDLT_ADDR_W-1:0] WDLT_OFF_MASK = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // Control fields
  localparam int WDLT_SEL_W = 4;
  localparam int WDLT_INT_SEL_LSB = 0;
  localparam int WDLT_RST_SEL_LSB = 4;
  localparam int WDLT_EN_BIT = 8;
  localparam int WDLT_LATE_BIT = 9;
  localparam int WDLT_INT_EN_BIT = 10;
  localparam int WDLT_RST_EN_BIT = 11;
  localparam logic [WDLT_SEL_W-1:0] WDLT_SEL_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Feed sequence
  localparam int WDLT_FEED_W = 8;
  localparam logic [WDLT_FEED_W-1:0] WDLT_FEED_FIRST = 8'hA5;
  localparam logic [WDLT_FEED_W-1:0] WDLT_FEED_SECOND = 8'h5A;

  ////////////////////////////////////////////////////////////////////////////////
  // Status and mask
  localparam int WDLT_ST_W = 2;
  localparam int WDLT_ST_LATE_INT = 0;
  localparam int WDLT_ST_LATE_RST = 1;
  localparam logic [WDLT_ST_W-1:0] WDLT_MASK_RESET = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter
  localparam int WDLT_CNT_W = 32;
  localparam int WDLT_THR_EXP_MAX = 31;
  localparam logic [WDLT_CNT_W-1:0] WDLT_CNT_ONE = 32'h1;
  localparam logic [WDLT_CNT_W-1:0] WDLT_CNT_MAX = 32'hFFFFFFFF;

  typedef enum logic [1:0]
  {
    WDLT_FEED_IDLE = 2'b01,
    WDLT_FEED_ARMED = 2'b10
  } wdlt_feed_state_type;

  // Threshold in counter periods: 2^(base_exp - code)
  function automatic logic [WDLT_CNT_W-1:0] wdlt_thr(input logic [WDLT_SEL_W-1:0] code, input int base_exp);
    wdlt_thr = WDLT_CNT_ONE << (base_exp - int'(code));
  endfunction

endpackage

//--- wdlt_cnt_if.sv
`timescale 1ns/100ps
interface wdlt_cnt_if;
  logic run;
  logic clear;
  logic [wdlt_pkg::WDLT_SEL_W-1:0] int_sel;
  logic [wdlt_pkg::WDLT_SEL_W-1:0] rst_sel;
  logic [wdlt_pkg::WDLT_CNT_W-1:0] count;
  logic int_hit;
  logic rst_hit;

  modport ctl (output run, output clear, output int_sel, output rst_sel,
               input count, input int_hit, input rst_hit);
  modport cnt (input run, input clear, input int_sel, input rst_sel,
               output count, output int_hit, output rst_hit);
endinterface // wdlt_cnt_if

//--- wdlt_counter.sv
`timescale 1ns/100ps
module wdlt_counter #(
  parameter int thr_base_exp = wdlt_pkg::WDLT_THR_EXP_MAX
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Control side
  wdlt_cnt_if.cnt cnt_if
);
  import wdlt_pkg::*;

  logic [WDLT_CNT_W-1:0] count_reg;
  logic [WDLT_CNT_W-1:0] count_next;
  logic [WDLT_CNT_W-1:0] int_thr;
  logic [WDLT_CNT_W-1:0] rst_thr;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter; saturates so a long stall never wraps into a second event
  always_comb
  begin
    count_next = count_reg;
    if (cnt_if.clear)
      count_next = '0;
    else if (cnt_if.run && (count_reg != WDLT_CNT_MAX))
      count_next = count_reg + WDLT_CNT_ONE;
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign int_thr = wdlt_thr(cnt_if.int_sel, thr_base_exp);
  assign rst_thr = wdlt_thr(cnt_if.rst_sel, thr_base_exp);

  // A hit marks the edge on which the count arrives at the threshold
  assign cnt_if.int_hit = cnt_if.run && !cnt_if.clear && (count_reg == int_thr - WDLT_CNT_ONE);
  assign cnt_if.rst_hit = cnt_if.run && !cnt_if.clear && (count_reg == rst_thr - WDLT_CNT_ONE);
  assign cnt_if.count = count_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  int_thr_a: assert property (cnt_if.int_hit |=> count_reg == wdlt_thr($past(cnt_if.int_sel), thr_base_exp))
    else $error("interrupt hit not at selected threshold");
  rst_thr_a: assert property (cnt_if.rst_hit |=> count_reg == wdlt_thr($past(cnt_if.rst_sel), thr_base_exp))
    else $error("reset hit not at selected threshold");
  clear_zero_a: assert property (cnt_if.clear |=> count_reg == '0)
    else $error("counter not cleared by feed");
endmodule // wdlt_counter

//--- wdlt_top.sv
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
module wdlt_top #(
  parameter int thr_base_exp = wdlt_pkg::WDLT_THR_EXP_MAX
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [wdlt_pkg::WDLT_ADDR_W-1:0] addr_in,
  input wire logic [wdlt_pkg::WDLT_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [wdlt_pkg::WDLT_DATA_W-1:0] rdata_out,
  // Watchdog events
  output logic irq_out,
  output logic rst_req_out
);
  import wdlt_pkg::*;

  function automatic logic is_at(input logic [WDLT_ADDR_W-1:0] a, input logic [WDLT_ADDR_W-1:0] off);
    is_at = (a == off);
  endfunction

  wdlt_cnt_if cnt_bus();

  logic wr_ctrl;
  logic wr_feed;
  logic wr_stat;
  logic wr_mask;
  logic [WDLT_FEED_W-1:0] feed_byte;
  logic feed_done;
  wdlt_feed_state_type feed_state_reg;
  wdlt_feed_state_type feed_state_next;
  logic en_reg;
  logic en_next;
  logic int_en_reg;
  logic int_en_next;
  logic rst_en_reg;
  logic rst_en_next;
  logic [WDLT_SEL_W-1:0] int_sel_reg;
  logic [WDLT_SEL_W-1:0] int_sel_next;
  logic [WDLT_SEL_W-1:0] rst_sel_reg;
  logic [WDLT_SEL_W-1:0] rst_sel_next;
  logic [WDLT_ST_W-1:0] status_reg;
  logic [WDLT_ST_W-1:0] status_next;
  logic [WDLT_ST_W-1:0] status_set;
  logic [WDLT_ST_W-1:0] status_clr;
  logic [WDLT_ST_W-1:0] mask_reg;
  logic [WDLT_ST_W-1:0] mask_next;
  logic irq_reg;
  logic irq_next;
  logic rst_req_reg;
  logic rst_req_next;
  logic [WDLT_DATA_W-1:0] rdata_reg;
  logic [WDLT_DATA_W-1:0] rdata_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_ctrl = wr_in && is_at(addr_in, WDLT_OFF_CTRL);
  assign wr_feed = wr_in && is_at(addr_in, WDLT_OFF_FEED);
  assign wr_stat = wr_in && is_at(addr_in, WDLT_OFF_STAT);
  assign wr_mask = wr_in && is_at(addr_in, WDLT_OFF_MASK);
  assign feed_byte = wdata_in[WDLT_FEED_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Feed sequence: the two writes must be consecutive bus writes
  always_comb
  begin
    feed_state_next = feed_state_reg;
    feed_done = 1'b0;
    case (feed_state_reg)
      WDLT_FEED_IDLE:
      begin
        if (wr_feed && (feed_byte == WDLT_FEED_FIRST))
          feed_state_next = WDLT_FEED_ARMED;
      end
      WDLT_FEED_ARMED:
      begin
        if (wr_feed && (feed_byte == WDLT_FEED_SECOND))
          feed_done = 1'b1;
        // Any other write breaks the pair; a repeated first byte re-arms
        if (wr_in)
        begin
          if (wr_feed && (feed_byte == WDLT_FEED_FIRST))
            feed_state_next = WDLT_FEED_ARMED;
          else
            feed_state_next = WDLT_FEED_IDLE;
        end
      end
      default:
        feed_state_next = WDLT_FEED_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      feed_state_reg <= WDLT_FEED_IDLE;
    else
      feed_state_reg <= feed_state_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register
  always_comb
  begin
    en_next = en_reg;
    int_en_next = int_en_reg;
    rst_en_next = rst_en_reg;
    int_sel_next = int_sel_reg;
    rst_sel_next = rst_sel_reg;
    if (wr_ctrl)
    begin
      // enable bit; timing is left to software
      en_next = wdata_in[WDLT_EN_BIT];
      int_en_next = wdata_in[WDLT_INT_EN_BIT];
      rst_en_next = wdata_in[WDLT_RST_EN_BIT];
      // selectors frozen while running, keeps thresholds coherent
      if (!en_reg)
      begin
        int_sel_next = wdata_in[WDLT_INT_SEL_LSB +: WDLT_SEL_W];
        rst_sel_next = wdata_in[WDLT_RST_SEL_LSB +: WDLT_SEL_W];
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      en_reg <= 1'b0;
      int_en_reg <= 1'b0;
      rst_en_reg <= 1'b0;
      int_sel_reg <= WDLT_SEL_RESET;
      rst_sel_reg <= WDLT_SEL_RESET;
    end
    else
    begin
      en_reg <= en_next;
      int_en_reg <= int_en_next;
      rst_en_reg <= rst_en_next;
      int_sel_reg <= int_sel_next;
      rst_sel_reg <= rst_sel_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter
  assign cnt_bus.run = en_reg;
  assign cnt_bus.clear = feed_done;
  assign cnt_bus.int_sel = int_sel_reg;
  assign cnt_bus.rst_sel = rst_sel_reg;

  wdlt_counter #(
    .thr_base_exp(thr_base_exp)
  ) u_counter (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .cnt_if(cnt_bus.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Status, mask, interrupt and reset request
  always_comb
  begin
    status_set = '0;
    status_clr = '0;
    status_set[WDLT_ST_LATE_INT] = cnt_bus.int_hit;
    status_set[WDLT_ST_LATE_RST] = cnt_bus.rst_hit;
    if (wr_stat)
      status_clr = wdata_in[WDLT_ST_W-1:0];
    if (wr_ctrl && wdata_in[WDLT_LATE_BIT])
      status_clr[WDLT_ST_LATE_INT] = 1'b1;
    // Set wins over a clear in the same cycle so no event is lost
    status_next = (status_reg & ~status_clr) | status_set;
    mask_next = wr_mask ? wdata_in[WDLT_ST_W-1:0] : mask_reg;
    irq_next = int_en_next && (|(status_next & mask_next));
    rst_req_next = rst_en_reg && cnt_bus.rst_hit;
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      status_reg <= '0;
      mask_reg <= WDLT_MASK_RESET;
      irq_reg <= 1'b0;
      rst_req_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      rst_req_reg <= rst_req_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data valid only in the cycle after the strobe
  always_comb
  begin
    rdata_next = '0;
    if (rd_in)
    begin
      case (addr_in)
        WDLT_OFF_CTRL:
        begin
          rdata_next[WDLT_INT_SEL_LSB +: WDLT_SEL_W] = int_sel_reg;
          rdata_next[WDLT_RST_SEL_LSB +: WDLT_SEL_W] = rst_sel_reg;
          rdata_next[WDLT_EN_BIT] = en_reg;
          rdata_next[WDLT_LATE_BIT] = status_reg[WDLT_ST_LATE_INT];
          rdata_next[WDLT_INT_EN_BIT] = int_en_reg;
          rdata_next[WDLT_RST_EN_BIT] = rst_en_reg;
        end
        WDLT_OFF_CNT:
          rdata_next[WDLT_CNT_W-1:0] = cnt_bus.count;
        WDLT_OFF_STAT:
          rdata_next[WDLT_ST_W-1:0] = status_reg;
        WDLT_OFF_MASK:
          rdata_next[WDLT_ST_W-1:0] = mask_reg;
        default:
          rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  assign rdata_out = rdata_reg;
  assign irq_out = irq_reg;
  assign rst_req_out = rst_req_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  feed_clear_a: assert property (
    (feed_state_reg == WDLT_FEED_ARMED) && wr_feed && (feed_byte == WDLT_FEED_SECOND)
    |=> cnt_bus.count == '0)
    else $error("completed feed did not clear counter");

  late_flag_a: assert property (cnt_bus.int_hit |=> status_reg[WDLT_ST_LATE_INT])
    else $error("late flag not set on interrupt threshold");

  set_wins_a: assert property (
    cnt_bus.int_hit && wr_stat && wdata_in[WDLT_ST_LATE_INT] |=> status_reg[WDLT_ST_LATE_INT])
    else $error("clear overrode a simultaneous late event");

  irq_gate_a: assert property (irq_out |-> int_en_reg)
    else $error("interrupt high while interrupt-allow is clear");

  irq_level_a: assert property (
    int_en_reg && status_reg[WDLT_ST_LATE_INT] && mask_reg[WDLT_ST_LATE_INT] |-> irq_out)
    else $error("unmasked late flag did not raise interrupt");

  off_hold_a: assert property (!en_reg && !feed_done |=> $stable(cnt_bus.count))
    else $error("counter moved while disabled");

  sel_freeze_a: assert property (en_reg |=> $stable(int_sel_reg) && $stable(rst_sel_reg))
    else $error("threshold selector changed while running");

  rst_req_a: assert property (cnt_bus.rst_hit && rst_en_reg |=> rst_req_out ##1 !rst_req_out)
    else $error("reset request not a one-cycle pulse at reset threshold");

  rst_block_a: assert property (rst_req_out |-> $past(rst_en_reg) && $past(cnt_bus.rst_hit))
    else $error("reset request without reset-allow and threshold");

  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == '0)
    else $error("read data outside the read answer cycle");

  rst_flag_a: assert property (cnt_bus.rst_hit |=> status_reg[WDLT_ST_LATE_RST])
    else $error("late reset event not recorded");

  rst_gate_a: assert property (!rst_en_reg |=> !rst_req_out)
    else $error("reset request while reset-allow is clear");

  irq_quiet_a: assert property (!(|(status_reg & mask_reg)) |-> !irq_out)
    else $error("interrupt high with no unmasked event");

  irq_clear_a: assert property (
    wr_stat && (&wdata_in[WDLT_ST_W-1:0]) && !cnt_bus.int_hit && !cnt_bus.rst_hit |=> !irq_out)
    else $error("interrupt stayed high after both events were cleared");

  en_off_a: assert property (wr_ctrl && !wdata_in[WDLT_EN_BIT] |=> !en_reg)
    else $error("enable bit did not clear");

  en_read_a: assert property (
    rd_in && is_at(addr_in, WDLT_OFF_CTRL) |=> rdata_out[WDLT_EN_BIT] == $past(en_reg))
    else $error("enable bit read back wrong");

  sel_take_a: assert property (
    wr_ctrl && !en_reg
    |=> int_sel_reg == $past(wdata_in[WDLT_INT_SEL_LSB +: WDLT_SEL_W])
    && rst_sel_reg == $past(wdata_in[WDLT_RST_SEL_LSB +: WDLT_SEL_W]))
    else $error("selector write while stopped not taken");

  feed_break_a: assert property (
    (feed_state_reg == WDLT_FEED_ARMED) && wr_in && !wr_feed |=> feed_state_reg == WDLT_FEED_IDLE)
    else $error("foreign write did not break the feed pair");

  count_run_a: assert property (
    en_reg && !feed_done && (cnt_bus.count != WDLT_CNT_MAX)
    |=> cnt_bus.count == $past(cnt_bus.count) + WDLT_CNT_ONE)
    else $error("running counter did not advance");

  late_rst_c: cover property (cnt_bus.rst_hit && !rst_en_reg);
  feed_cov_c: cover property (feed_done);
  irq_rise_c: cover property ($rose(irq_out));
  rst_req_c: cover property (rst_req_out);
  set_clear_c: cover property (cnt_bus.int_hit && wr_stat && wdata_in[WDLT_ST_LATE_INT]);
endmodule // wdlt_top

//--- tb_watchdog_late_threshold_control.sv
`timescale 1ns/100ps
module tb_watchdog_late_threshold_control;
  import wdlt_pkg::*;
  // Shortened base so code 0xF gives 8 cycles and 0xE gives 16
  localparam int base_exp = 18;
  logic clock_in;
  logic resetn_in;
  logic wr_in;
  logic rd_in;
  logic irq_out;
  logic rst_req_out;
  logic [WDLT_ADDR_W-1:0] addr_in;
  logic [WDLT_DATA_W-1:0] wdata_in;
  logic [WDLT_DATA_W-1:0] rdata_out;
  logic [WDLT_DATA_W-1:0] rd_val;
  int err_count;
  int cmp_count;

  wdlt_top #(.thr_base_exp(base_exp)) dut_u (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .irq_out(irq_out),
    .rst_req_out(rst_req_out)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Strobe is left high so writes can run back to back; idle or a read lowers it
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    rd_in <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    wr_in <= 1'b0;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 rd_val = rdata_out;
  endtask

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clock_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
    end
  endtask

  task automatic feed;
    bus_wr(WDLT_OFF_FEED, {24'h0, WDLT_FEED_FIRST});
    bus_wr(WDLT_OFF_FEED, {24'h0, WDLT_FEED_SECOND});
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] isel, input logic [3:0] rsel, input logic en,
                                      input logic ia, input logic ra);
    ctl = {24'h0, rsel, isel};
    ctl[WDLT_EN_BIT] = en;
    ctl[WDLT_INT_EN_BIT] = ia;
    ctl[WDLT_RST_EN_BIT] = ra;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values;
    bus_rd(WDLT_OFF_CTRL);
    check(rd_val, 32'h0, "control after reset");
    bus_rd(WDLT_OFF_MASK);
    check(rd_val, 32'h3, "mask after reset");
    bus_rd(WDLT_OFF_STAT);
    check(rd_val, 32'h0, "status after reset");
    bus_wr(8'h20, 32'hFFFFFFFF);
    bus_rd(8'h20);
    check(rd_val, 32'h0, "unmapped read");
    idle(5);
    bus_rd(WDLT_OFF_CNT);
    check(rd_val, 32'h0, "disabled counter idle");
    bus_wr(WDLT_OFF_CTRL, ctl(4'hA, 4'h5, 1'b0, 1'b1, 1'b1));
    bus_rd(WDLT_OFF_CTRL);
    check(rd_val, ctl(4'hA, 4'h5, 1'b0, 1'b1, 1'b1), "control read back");
  endtask

  task automatic t_late_events;
    int rs;
    int ir;
    int pulses;
    rs = -1;
    ir = -1;
    pulses = 0;
    // Late-reset event masked out so the interrupt marks only its own threshold
    bus_wr(WDLT_OFF_MASK, 32'h1);
    bus_wr(WDLT_OFF_CTRL, ctl(4'hE, 4'hF, 1'b0, 1'b1, 1'b1));
    feed();
    bus_wr(WDLT_OFF_CTRL, ctl(4'hE, 4'hF, 1'b1, 1'b1, 1'b1));
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clock_in);
      wr_in <= 1'b0;
      #1;
      if (rst_req_out === 1'b1)
        pulses++;
      if (rst_req_out === 1'b1 && rs < 0)
        rs = i;
      if (irq_out === 1'b1 && ir < 0)
        ir = i;
    end
    check(rs, 32'd8, "reset threshold 8");
    check(ir - rs, 32'd8, "interrupt threshold 16");
    check(pulses, 32'd1, "single reset pulse");
    bus_rd(WDLT_OFF_STAT);
    check(rd_val, 32'h3, "both events");
    bus_rd(WDLT_OFF_CTRL);
    check(rd_val[WDLT_LATE_BIT], 32'h1, "late flag");
    bus_wr(WDLT_OFF_STAT, 32'h3);
    idle(1);
    #1 check({31'h0, irq_out}, 32'h0, "irq after clear");
    feed();
    bus_wr(WDLT_OFF_CTRL, 32'h0);
  endtask

  task automatic t_irq_gate;
    int pulses;
    pulses = 0;
    bus_wr(WDLT_OFF_CTRL, ctl(4'hF, 4'hF, 1'b0, 1'b0, 1'b0));
    feed();
    bus_wr(WDLT_OFF_CTRL, ctl(4'hF, 4'hF, 1'b1, 1'b0, 1'b0));
    // Status clear timed onto the edge where both events set; the set must win
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clock_in);
      if (i == 7)
      begin
        addr_in <= WDLT_OFF_STAT;
        wdata_in <= 32'h3;
      end
      wr_in <= (i == 7);
      #1;
      if (irq_out !== 1'b0 || rst_req_out !== 1'b0)
        pulses++;
    end
    check(pulses, 32'd0, "gated outputs quiet");
    bus_rd(WDLT_OFF_STAT);
    check(rd_val, 32'h3, "events set while gated");
    // Selector change while running is refused
    bus_wr(WDLT_OFF_CTRL, ctl(4'h3, 4'h3, 1'b1, 1'b1, 1'b0));
    idle(1);
    #1 check({31'h0, irq_out}, 32'h1, "irq once allowed");
    bus_wr(WDLT_OFF_MASK, 32'h0);
    idle(1);
    #1 check({31'h0, irq_out}, 32'h0, "irq masked");
    bus_wr(WDLT_OFF_MASK, 32'h1);
    idle(1);
    #1 check({31'h0, irq_out}, 32'h1, "irq unmasked");
    bus_wr(WDLT_OFF_CTRL, ctl(4'hF, 4'hF, 1'b1, 1'b1, 1'b0) | 32'h200);
    idle(1);
    #1 check({31'h0, irq_out}, 32'h0, "irq after flag clear");
    bus_rd(WDLT_OFF_CTRL);
    check(rd_val, ctl(4'hF, 4'hF, 1'b1, 1'b1, 1'b0), "selectors held");
    bus_wr(WDLT_OFF_STAT, 32'h3);
    bus_wr(WDLT_OFF_MASK, 32'h3);
    feed();
    bus_wr(WDLT_OFF_CTRL, 32'h0);
  endtask

  task automatic t_feed;
    logic [31:0] held;
    bus_wr(WDLT_OFF_CTRL, 32'h0);
    feed();
    bus_wr(WDLT_OFF_CTRL, ctl(4'h0, 4'h0, 1'b1, 1'b0, 1'b0));
    idle(20);
    bus_wr(WDLT_OFF_FEED, {24'h0, WDLT_FEED_FIRST});
    bus_wr(WDLT_OFF_MASK, 32'h3);
    bus_wr(WDLT_OFF_FEED, {24'h0, WDLT_FEED_SECOND});
    bus_rd(WDLT_OFF_CNT);
    check({31'h0, rd_val >= 32'd20}, 32'h1, "broken feed ignored");
    bus_wr(WDLT_OFF_FEED, {24'h0, WDLT_FEED_FIRST});
    bus_rd(WDLT_OFF_CNT);
    bus_wr(WDLT_OFF_FEED, {24'h0, WDLT_FEED_SECOND});
    bus_rd(WDLT_OFF_CNT);
    check(rd_val, 32'h0, "feed clears counter");
    feed();
    bus_wr(WDLT_OFF_CTRL, 32'h0);
    idle(3);
    bus_rd(WDLT_OFF_CNT);
    held = rd_val;
    idle(6);
    bus_rd(WDLT_OFF_CNT);
    check(rd_val, held, "disabled counter holds");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Run control
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    err_count = 0;
    cmp_count = 0;
    resetn_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = '0;
    wdata_in = '0;
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    idle(1);
    t_reset_values();
    t_late_events();
    t_irq_gate();
    t_feed();
    wrap_up();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    #200000;
    err_count++;
    wrap_up();
  end
endmodule // tb_watchdog_late_threshold_control
